// file: dv/spi_peer_model.sv
// Purpose: behavioural serial peer selected by the bench
// Assumes: bench drives select, mode and the byte to return
// Notes:   released miso shows the inverse of its last level
`timescale 1ns/1ns
module spi_peer_model (
  // link pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       slow,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  int n;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
  end
  always @(negedge ss_n) begin
    n = cpha ? 0 : 1;
    miso <= cpha ? ~miso : tx_byte[7];
  end
  always @(sck) begin
    if (!ss_n && (sck ^ cpol ^ cpha)) begin
      rx_byte <= {rx_byte[6:0], mosi};
    end else if (!ss_n && n < 8) begin
      miso <= #(slow ? 30 : 0) tx_byte[7 - n];
      n = n + 1;
    end
  end
  always @(posedge ss_n) miso <= ~miso;
endmodule

// file: dv/spi_regs_checker_assertions.sv
// Purpose: bus and pin checks for the serial port
// Assumes: one aclk domain, ce held high
// Notes:   bound to the top module
`timescale 1ns/1ns
module spi_regs_checker
  import spi_port_pkg::*;
(
  // clock and reset
  input wire logic                              aclk,
  input wire logic                              aresetn,
  // register bus
  input wire logic                              s_axi_awvalid,
  input wire logic                              s_axi_awready,
  input wire logic [spi_port_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                              s_axi_wvalid,
  input wire logic                              s_axi_wready,
  input wire logic                              s_axi_bvalid,
  input wire logic                              s_axi_bready,
  input wire logic [1:0]                        s_axi_bresp,
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic [spi_port_pkg::ADDR_W-1:0]   s_axi_araddr,
  input wire logic                              s_axi_rvalid,
  input wire logic                              s_axi_rready,
  input wire logic [spi_port_pkg::DATA_W-1:0]   s_axi_rdata,
  input wire logic [1:0]                        s_axi_rresp,
  // pins and interrupt
  input wire spi_port_pkg::spi_pins_in_t        pins_i,
  input wire spi_port_pkg::spi_pins_out_t       pins_o,
  input wire logic                              ss_pin_input,
  input wire logic [1:0]                        irq_level_sel
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic bad_w;
  logic bad_r;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) bad_w <= s_axi_awaddr[4:2] > 3'h5;
  end
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) bad_r <= s_axi_araddr[4:2] > 3'h5;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_resp;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (s_wr_take |=> s_wr_resp)
    else $error("write response not on time");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not on time");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == (bad_w ? RESP_SLVERR : RESP_OKAY))
    else $error("wrong write response code");
  rresp_code_a: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp == (bad_r ? RESP_SLVERR : RESP_OKAY))
    else $error("wrong read response code");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  irq_lvl_a: assert property ($changed(irq_level_sel) |-> !s_axi_awready || $past(!s_axi_awready))
    else $error("irq level changed without a write");
  mode_fault_a: assert property ((ss_pin_input && !pins_i.ss_n) [*8] |-> !pins_o.sck_oe)
    else $error("clock still driven after select fault");
endmodule
bind spi_status_data_regs spi_regs_checker i_chk (.*);

// file: dv/testbench.sv
// Purpose: self-checking bench for the serial port registers and link
// Assumes: ce held high, peer acts as the selected slave
// Notes:   slow divisors keep miso clear of the input synchroniser lag
`timescale 1ns/1ns
module testbench;
  import spi_port_pkg::*;
  localparam logic [4:0] A_CTL = {IDX_PORT_CONTROL, 2'b00};
  localparam logic [4:0] A_IRQ = {IDX_IRQ_SETUP, 2'b00};
  localparam logic [4:0] A_FLG = {IDX_FLAG_REPORT, 2'b00};
  localparam logic [4:0] A_DAT = {IDX_SHIFT_DATA, 2'b00};
  localparam logic [4:0] A_EVS = {IDX_EVT_STATUS, 2'b00};
  localparam logic [4:0] A_MSK = {IDX_EVT_MASK, 2'b00};
  localparam int DIV[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic                aclk, aresetn, ce, irq, irq_ack, ss_pin_input, ss_n_pin;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, peer_ss_n, peer_miso, cpol, cpha, slow;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, irq_level_sel;
  logic [7:0]          peer_tx, peer_rx;
  spi_pins_in_t        pins_i;
  spi_pins_out_t       pins_o;
  int                  err_total, comparisons, hi_cnt;
  assign pins_i = '{sck: pins_o.sck_o, mosi: pins_o.mosi_o, miso: peer_miso, ss_n: ss_n_pin};
  spi_status_data_regs i_dut (.*);
  spi_peer_model i_peer (.sck(pins_o.sck_o), .mosi(pins_o.mosi_o), .ss_n(peer_ss_n),
    .miso(peer_miso), .cpol, .cpha, .slow, .tx_byte(peer_tx), .rx_byte(peer_rx));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (pins_o.sck_o === 1'b1) hi_cnt <= hi_cnt + 1;
  function automatic logic [7:0] rev(input logic [7:0] v);
    rev = {<<{v}};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic put(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic expect_reg(input logic [4:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
  endtask
  task automatic poll(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    logic [7:0] d;
    logic [1:0] r;
    d = ~e;
    for (int i = 0; i < 400 && (d & m) !== e; i++) rd(a, d, r);
    chk(n, e, d & m);
  endtask
  task automatic t_reset_map();
    logic [7:0] d;
    logic [1:0] r;
    expect_reg(A_CTL, PORT_CONTROL_RST, "port_control reset");
    expect_reg(A_IRQ, IRQ_SETUP_RST, "irq_setup reset");
    expect_reg(A_MSK, 8'h00, "evt_mask reset");
    put(A_FLG, 8'hC0);
    expect_reg(A_FLG, 8'h00, "flag_report read only");
    rd(5'h18, d, r);
    chk("unmapped read resp", RESP_SLVERR, r);
    wr(5'h1C, 8'h5A, r);
    chk("unmapped write resp", RESP_SLVERR, r);
  endtask
  task automatic t_modes();
    logic [7:0] tx;
    for (int m = 0; m < 4; m++) begin
      tx = 8'hA1 + 8'(m * 37);
      cpol <= m[1];
      cpha <= m[0];
      slow <= m[0];
      peer_tx <= ~tx;
      put(A_CTL, {2'b01, m[0], 1'b1, m[1:0], 2'b01});
      peer_ss_n <= 1'b0;
      put(A_DAT, tx);
      poll(A_FLG, 8'h80, 8'h80, "done flag");
      chk("irq with level zero", 1'b0, irq);
      chk("mosi byte", m[0] ? rev(tx) : tx, peer_rx);
      expect_reg(A_DAT, m[0] ? rev(~tx) : ~tx, "received byte");
      expect_reg(A_FLG, 8'h00, "flags after clear");
      peer_ss_n <= 1'b1;
    end
  endtask
  task automatic t_rates();
    int s;
    cpol <= 1'b0;
    cpha <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      put(A_CTL, {k[2], 1'b1, 1'b0, 1'b1, 2'b00, k[1:0]});
      s = hi_cnt;
      put(A_DAT, 8'h96);
      poll(A_FLG, 8'h80, 8'h80, "done flag");
      chk("sck high cycles", 4 * DIV[k], hi_cnt - s);
      expect_reg(A_DAT, {8{peer_miso}}, "idle miso byte");
    end
  endtask
  task automatic t_collision();
    logic [7:0] d;
    logic [1:0] r;
    put(A_EVS, 8'h07);
    put(A_CTL, 8'h53);
    put(A_IRQ, 8'h01);
    put(A_DAT, 8'h3C);
    put(A_DAT, 8'hC3);
    expect_reg(A_FLG, 8'h40, "collision flag");
    for (int i = 0; i < 1500 && irq !== 1'b1; i++) @(posedge aclk);
    chk("irq on done", 1'b1, irq);
    rd(A_DAT, d, r);
    expect_reg(A_FLG, 8'h80, "done kept");
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    expect_reg(A_FLG, 8'h00, "done after ack");
    chk("irq after ack", 1'b0, irq);
    expect_reg(A_EVS, 8'h03, "event status");
    put(A_MSK, 8'h01);
    expect_reg(A_MSK, 8'h01, "event mask");
    chk("irq from event", 1'b1, irq);
    put(A_EVS, 8'h01);
    expect_reg(A_EVS, 8'h02, "event cleared");
    chk("irq event cleared", 1'b0, irq);
    put(A_MSK, 8'h00);
    put(A_IRQ, 8'h00);
  endtask
  task automatic t_fault();
    put(A_CTL, 8'h50);
    ss_pin_input <= 1'b1;
    ss_n_pin <= 1'b0;
    poll(A_CTL, 8'h10, 8'h00, "master bit after fault");
    expect_reg(A_FLG, 8'h80, "done on fault");
    ss_n_pin <= 1'b1;
    ss_pin_input <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    wrap_up();
  end
  initial begin
    {err_total, comparisons, hi_cnt} = '0;
    {ce, ss_n_pin, peer_ss_n} = 3'b111;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {irq_ack, ss_pin_input, cpol, cpha, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, peer_tx} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_modes();
    t_rates();
    t_collision();
    t_fault();
    wrap_up();
  end
endmodule

// file: verilog/spi_port_pkg.sv
// Purpose: shared constants and carriers for the byte-wide serial port
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low byte lane
// Notes:   register index times four gives the byte address
package spi_port_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // register indices and byte addresses
  localparam logic [2:0] IDX_PORT_CONTROL = 3'h0;
  localparam logic [2:0] IDX_IRQ_SETUP    = 3'h1;
  localparam logic [2:0] IDX_FLAG_REPORT  = 3'h2;
  localparam logic [2:0] IDX_SHIFT_DATA   = 3'h3;
  localparam logic [2:0] IDX_EVT_STATUS   = 3'h4;
  localparam logic [2:0] IDX_EVT_MASK     = 3'h5;

  // port_control fields
  localparam int unsigned CTL_RATE_DOUBLE = 7;
  localparam int unsigned CTL_ENABLE      = 6;
  localparam int unsigned CTL_BIT_ORDER   = 5;
  localparam int unsigned CTL_MASTER      = 4;
  localparam int unsigned CTL_CPOL        = 3;
  localparam int unsigned CTL_CPHA        = 2;
  localparam int unsigned CTL_PRESC_HI    = 1;
  localparam int unsigned CTL_PRESC_LO    = 0;

  // irq_setup field
  localparam int unsigned IRQ_LVL_HI = 1;
  localparam int unsigned IRQ_LVL_LO = 0;

  // flag_report fields
  localparam int unsigned FLG_DONE      = 7;
  localparam int unsigned FLG_COLLISION = 6;

  // event status / mask fields
  localparam int unsigned EVT_DONE      = 0;
  localparam int unsigned EVT_COLLISION = 1;
  localparam int unsigned EVT_FAULT     = 2;
  localparam int unsigned EVT_W         = 3;

  // reset values
  localparam logic [7:0]       PORT_CONTROL_RST = 8'h00;
  localparam logic [7:0]       IRQ_SETUP_RST    = 8'h00;
  localparam logic [EVT_W-1:0] EVT_MASK_RST     = 3'h0;

  // serial clock half periods in peripheral clocks (divisor / 2)
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_DIV2   = 7'h01;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV32  = 7'h10;

  // index of the last of the 16 clock edges per byte
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} engine_state_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spi_pins_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spi_pins_out_t;

endpackage

// file: verilog/spi_status_data_regs.sv
// Purpose: byte-wide serial port with control, irq setup, status and data registers
// Assumes: 100 MHz aclk, AXI4-Lite slave, pins synchronised by two flops
// Notes:   ce low freezes all state
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns

// Operation
// R1 - nonzero irq level enables interrupt, raised while transfer-done flag set
// R2 - software writes zeros to reserved irq setup and status bits
// R3 - transfer-done flag, status bit 7, set when a full byte shifted
// R4 - master with select input driven low also sets transfer-done flag
// R5 - interrupt vector acknowledge clears transfer-done flag
// R6 - status read with done set, then data access, clears done flag
// R7 - data write during a transfer sets collision flag, status bit 6
// R8 - collision flag cleared only by status read then data access
// R9 - data write starts transmission, byte shifted out serially
// R10 - data read returns most recent completely received byte
// R11 - control fields: double, enable, lsb-first, master, mode, prescaler
// R12 - master clock divides by 4/16/64/128, or 2/8/32/64 when doubled
// R13 - mode picks clock idle level and sample on leading or trailing edge
// R14 - select input low in master mode clears master bit, falls to slave
// R15 - clear sequence only clears flags that were set at status read
module spi_status_data_regs
  import spi_port_pkg::*;
(
  // clock, reset, enable
  input  wire  logic                          aclk,
  input  wire  logic                          aresetn,
  input  wire  logic                          ce,
  // axi4-lite write address
  input  wire  logic                          s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire  logic [spi_port_pkg::ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire  logic                          s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire  logic [spi_port_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire  logic [3:0]                    s_axi_wstrb,
  // axi4-lite write response
  output logic                                s_axi_bvalid,
  input  wire  logic                          s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  // axi4-lite read address
  input  wire  logic                          s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire  logic [spi_port_pkg::ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic                                s_axi_rvalid,
  input  wire  logic                          s_axi_rready,
  output logic [spi_port_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  // serial pins
  input  wire  spi_port_pkg::spi_pins_in_t    pins_i,
  output spi_port_pkg::spi_pins_out_t         pins_o,
  input  wire  logic                          ss_pin_input,
  // interrupt
  input  wire  logic                          irq_ack,
  output logic                                irq,
  output logic [1:0]                          irq_level_sel
);
  import spi_port_pkg::*;

  spi_pins_in_t     pin_s1;
  spi_pins_in_t     pin_s2;
  logic             sck_s3;
  logic [7:0]       port_control;
  logic [7:0]       irq_setup;
  logic             flag_done;
  logic             write_collision_flag;
  logic             armed_done;
  logic             armed_coll;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  engine_state_t    state;
  logic [6:0]       div_cnt;
  logic [3:0]       edge_cnt;
  logic             sck_level;
  logic [7:0]       tx_sh;
  logic [7:0]       rx_sh;
  logic [7:0]       rx_buf;
  logic             done_pulse;
  logic             aw_held;
  logic             w_held;
  logic [2:0]       aw_idx;
  logic [7:0]       w_byte;
  logic             w_lane0;
  logic             aw_bad;
  logic [6:0]       half_period;
  logic             busy;
  logic             fault;
  logic             wr_fire;
  logic             rd_fire;
  logic [2:0]       ar_idx;
  logic             wr_data_reg;
  logic             data_access;
  logic             collision;
  logic             edge_evt;
  logic             leading;
  logic             sample;
  logic             in_bit;
  logic [7:0]       rx_next;
  logic             cpol;
  logic             cpha;
  logic             lsb_first;
  logic             is_master;
  logic             enabled;
  logic [7:0]       rd_byte;
  logic             rd_bad;

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  assign cpol      = port_control[CTL_CPOL];
  assign cpha      = port_control[CTL_CPHA];
  assign lsb_first = port_control[CTL_BIT_ORDER];
  assign is_master = port_control[CTL_MASTER];
  assign enabled   = port_control[CTL_ENABLE];

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
      pin_s2 <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
      sck_s3 <= 1'b0;
    end else if (ce) begin
      pin_s1 <= pins_i;
      pin_s2 <= pin_s1;
      sck_s3 <= pin_s2.sck;
    end
  end

  // R12 prescaler select
  always_comb begin
    unique case ({port_control[CTL_RATE_DOUBLE], port_control[CTL_PRESC_HI:CTL_PRESC_LO]})
      3'b000:  half_period = HALF_DIV4;
      3'b001:  half_period = HALF_DIV16;
      3'b010:  half_period = HALF_DIV64;
      3'b011:  half_period = HALF_DIV128;
      3'b100:  half_period = HALF_DIV2;
      3'b101:  half_period = HALF_DIV8;
      3'b110:  half_period = HALF_DIV32;
      default: half_period = HALF_DIV64;
    endcase
  end

  // bus decode
  assign wr_fire     = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire     = s_axi_arvalid && s_axi_arready;
  assign ar_idx      = s_axi_araddr[4:2];
  assign wr_data_reg = wr_fire && w_lane0 && (aw_idx == IDX_SHIFT_DATA);
  assign data_access = wr_data_reg || (rd_fire && ar_idx == IDX_SHIFT_DATA);
  assign busy        = (state == ST_MASTER) || (state == ST_SLAVE && edge_cnt != 4'h0);
  // R7 write during transfer
  assign collision   = wr_data_reg && busy;
  // R4 mode fault detect
  assign fault       = enabled && is_master && ss_pin_input && !pin_s2.ss_n;

  // R13 edge timing and sample/setup choice
  assign edge_evt = (state == ST_MASTER) ? (div_cnt == half_period - 7'h01)
                                         : (pin_s2.sck != sck_s3);
  assign leading  = !edge_cnt[0];
  assign sample   = leading ^ cpha;
  assign in_bit   = (state == ST_MASTER) ? pin_s2.miso : pin_s2.mosi;
  assign rx_next  = {rx_sh[6:0], in_bit};

  // shift engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= ST_IDLE;
      div_cnt    <= 7'h00;
      edge_cnt   <= 4'h0;
      sck_level  <= 1'b0;
      tx_sh      <= 8'h00;
      rx_sh      <= 8'h00;
      rx_buf     <= 8'h00;
      done_pulse <= 1'b0;
    end else if (ce) begin
      done_pulse <= 1'b0;
      // R9 load transmit byte, msb of tx_sh goes out first
      if (wr_data_reg && !busy) begin
        tx_sh <= lsb_first ? reverse8(w_byte) : w_byte;
      end
      unique case (state)
        ST_IDLE: begin
          sck_level <= cpol;
          div_cnt   <= 7'h00;
          edge_cnt  <= 4'h0;
          if (wr_data_reg && enabled && is_master && !fault) begin
            state <= ST_MASTER;
          end else if (enabled && !is_master && !pin_s2.ss_n) begin
            state <= ST_SLAVE;
          end
        end
        ST_MASTER: begin
          // R14 abort on fault
          if (fault || !enabled) begin
            state <= ST_IDLE;
          end else if (edge_evt) begin
            div_cnt   <= 7'h00;
            sck_level <= !sck_level;
            edge_cnt  <= edge_cnt + 4'h1;
            if (sample) begin
              rx_sh <= rx_next;
            end else if (!(cpha && edge_cnt == 4'h0)) begin
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
            // R3 byte complete
            if (edge_cnt == LAST_EDGE) begin
              rx_buf     <= lsb_first ? reverse8(sample ? rx_next : rx_sh)
                                      : (sample ? rx_next : rx_sh);
              done_pulse <= 1'b1;
              state      <= ST_IDLE;
            end
          end else begin
            div_cnt <= div_cnt + 7'h01;
          end
        end
        ST_SLAVE: begin
          // select high drops a partial byte
          if (pin_s2.ss_n || !enabled || is_master) begin
            state    <= ST_IDLE;
            edge_cnt <= 4'h0;
          end else if (edge_evt) begin
            edge_cnt <= edge_cnt + 4'h1;
            if (sample) begin
              rx_sh <= rx_next;
            end else if (!(cpha && edge_cnt == 4'h0)) begin
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
            if (edge_cnt == LAST_EDGE) begin
              // R10 receive buffer update
              rx_buf     <= lsb_first ? reverse8(sample ? rx_next : rx_sh)
                                      : (sample ? rx_next : rx_sh);
              done_pulse <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // axi write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 3'h0;
      aw_bad        <= 1'b0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx        <= s_axi_awaddr[4:2];
        aw_bad        <= (s_axi_awaddr[4:2] > IDX_EVT_MASK);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_bad ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    rd_bad  = 1'b0;
    unique case (ar_idx)
      IDX_PORT_CONTROL: rd_byte = port_control;
      IDX_IRQ_SETUP:    rd_byte = irq_setup;
      IDX_FLAG_REPORT:  rd_byte = {flag_done, write_collision_flag, 6'h00};
      // R10 data read
      IDX_SHIFT_DATA:   rd_byte = rx_buf;
      IDX_EVT_STATUS:   rd_byte = {5'h00, evt_status};
      IDX_EVT_MASK:     rd_byte = {5'h00, evt_mask};
      default:          rd_bad  = 1'b1;
    endcase
  end

  // axi read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_control <= PORT_CONTROL_RST;
      irq_setup    <= IRQ_SETUP_RST;
      evt_mask     <= EVT_MASK_RST;
    end else if (ce) begin
      // R11 control fields
      if (wr_fire && w_lane0 && aw_idx == IDX_PORT_CONTROL) begin
        port_control <= w_byte;
      end
      // R14 fall back to slave
      if (fault) begin
        port_control[CTL_MASTER] <= 1'b0;
      end
      // R2 reserved bits kept as zero
      if (wr_fire && w_lane0 && aw_idx == IDX_IRQ_SETUP) begin
        irq_setup <= {6'h00, w_byte[IRQ_LVL_HI:IRQ_LVL_LO]};
      end
      if (wr_fire && w_lane0 && aw_idx == IDX_EVT_MASK) begin
        evt_mask <= w_byte[EVT_W-1:0];
      end
    end
  end

  // status flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_done            <= 1'b0;
      write_collision_flag <= 1'b0;
      armed_done           <= 1'b0;
      armed_coll           <= 1'b0;
    end else if (ce) begin
      // R15 arm only flags set at status read
      if (rd_fire && ar_idx == IDX_FLAG_REPORT) begin
        armed_done <= flag_done;
        armed_coll <= write_collision_flag;
      end else if (data_access) begin
        armed_done <= 1'b0;
        armed_coll <= 1'b0;
      end
      // R3 R4 R5 R6 done flag
      if (done_pulse || fault) begin
        flag_done <= 1'b1;
      end else if (irq_ack || (data_access && armed_done)) begin
        flag_done <= 1'b0;
      end
      // R7 R8 collision flag
      if (collision) begin
        write_collision_flag <= 1'b1;
      end else if (data_access && armed_coll) begin
        write_collision_flag <= 1'b0;
      end
    end
  end

  // sticky events, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status <= '0;
    end else if (ce) begin
      for (int i = 0; i < EVT_W; i++) begin
        if ((i == EVT_DONE && done_pulse) || (i == EVT_COLLISION && collision)
            || (i == EVT_FAULT && fault)) begin
          evt_status[i] <= 1'b1;
        end else if (wr_fire && w_lane0 && aw_idx == IDX_EVT_STATUS && w_byte[i]) begin
          evt_status[i] <= 1'b0;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq           <= 1'b0;
      irq_level_sel <= 2'h0;
      pins_o        <= '0;
    end else if (ce) begin
      // R1 interrupt request
      irq           <= ((irq_setup[IRQ_LVL_HI:IRQ_LVL_LO] != 2'h0) && flag_done)
                       || (|(evt_status & evt_mask));
      irq_level_sel <= irq_setup[IRQ_LVL_HI:IRQ_LVL_LO];
      pins_o.sck_o   <= (state == ST_MASTER) ? sck_level : cpol;
      pins_o.sck_oe  <= enabled && is_master;
      pins_o.mosi_o  <= tx_sh[7];
      pins_o.mosi_oe <= enabled && is_master;
      pins_o.miso_o  <= tx_sh[7];
      pins_o.miso_oe <= enabled && !is_master && !pin_s2.ss_n;
    end
  end

endmodule
